// [src/occ_pkg.sv]
package occ_pkg;
  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_PRI    = 5'h04;
  localparam logic [4:0] ADDR_SEC    = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_MASK   = 5'h10;
  // Control field positions
  localparam int CTRL_ON_BIT    = 15;
  localparam int CTRL_WIDE_BIT  = 5;
  localparam int CTRL_TSEL_BIT  = 3;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int IRQ_CMP_BIT    = 0;
  // Writable control bits, reset values and the 16-bit compare mask
  localparam logic [31:0] CTRL_WMASK  = 32'h0000_802f;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [31:0] LOW16_MASK  = 32'h0000_ffff;
  // Mode encodings
  typedef enum logic [2:0] {
    MODE_OFF    = 3'b000,
    MODE_HIGH   = 3'b001,
    MODE_LOW    = 3'b010,
    MODE_TOGGLE = 3'b011,
    MODE_PULSE  = 3'b100
  } occ_mode_t;
  // Channel sequence
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b10,
    ST_DONE  = 2'b11
  } occ_state_t;
endpackage

// [src/occ_top.sv]
`timescale 1ns/10ps
module occ_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [31:0] timer_a_count_i,
  input  wire logic        timer_a_tick_i,
  input  wire logic [31:0] timer_b_count_i,
  input  wire logic        timer_b_tick_i,
  output logic             compare_output_pin_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] compare_control_reg, compare_control_next;
  logic [31:0] primary_compare_value_reg, primary_compare_value_next;
  logic [31:0] secondary_compare_value_reg, secondary_compare_value_next;
  logic [31:0] status_reg, status_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] dat_reg, dat_next;
  logic        ack_reg, ack_next;
  logic        pin_reg, pin_next;
  occ_pkg::occ_state_t state_reg, state_next;

  logic [31:0] byte_mask;
  logic        bus_hit;
  logic        ctrl_wr;
  logic        status_rd;
  logic [31:0] wr_ctrl;

  assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  // Writes land on the edge where the master sees ack, never earlier
  assign bus_hit   = cyc_i && stb_i && ack_reg;
  assign ctrl_wr   = bus_hit && we_i && (adr_i == occ_pkg::ADDR_CTRL);
  assign status_rd = bus_hit && !we_i && (adr_i == occ_pkg::ADDR_STATUS);
  assign wr_ctrl   = ((compare_control_reg & ~byte_mask) | (dat_i & byte_mask)) & occ_pkg::CTRL_WMASK;

  ////////////////////////////////////////////////////////////////////////////
  // Compare path
  logic        ctrl_on;
  logic        wide_compare_select;
  logic        time_base_select;
  logic [2:0]  compare_mode_field;
  logic [31:0] timer_count;
  logic        tick;
  logic [31:0] width_mask;
  logic        ev_pri;
  logic        ev_sec;
  logic        run;

  assign ctrl_on             = compare_control_reg[occ_pkg::CTRL_ON_BIT];
  assign wide_compare_select = compare_control_reg[occ_pkg::CTRL_WIDE_BIT];
  assign time_base_select    = compare_control_reg[occ_pkg::CTRL_TSEL_BIT];
  assign compare_mode_field  = compare_control_reg[occ_pkg::CTRL_MODE_LSB +: 3];
  assign timer_count = time_base_select ? timer_b_count_i : timer_a_count_i;
  assign tick        = time_base_select ? timer_b_tick_i : timer_a_tick_i;
  assign width_mask  = wide_compare_select ? '1 : occ_pkg::LOW16_MASK;
  // Tick qualifies equality so a stalled count cannot fire twice
  assign ev_pri = tick && ((timer_count & width_mask) == (primary_compare_value_reg & width_mask));
  assign ev_sec = tick && ((timer_count & width_mask) == (secondary_compare_value_reg & width_mask));
  assign run    = ctrl_on && (compare_mode_field != occ_pkg::MODE_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave
  always_comb
  begin
    compare_control_next         = compare_control_reg;
    primary_compare_value_next   = primary_compare_value_reg;
    secondary_compare_value_next = secondary_compare_value_reg;
    mask_next                    = mask_reg;
    ack_next                     = cyc_i && stb_i && !ack_reg;
    dat_next                     = 32'h0000_0000;
    if (bus_hit && we_i)
    begin
      case (adr_i)
        occ_pkg::ADDR_CTRL: compare_control_next = wr_ctrl;
        occ_pkg::ADDR_PRI:
          primary_compare_value_next = (primary_compare_value_reg & ~byte_mask) | (dat_i & byte_mask);
        occ_pkg::ADDR_SEC:
          secondary_compare_value_next = (secondary_compare_value_reg & ~byte_mask) | (dat_i & byte_mask);
        occ_pkg::ADDR_MASK:
          mask_next = ((mask_reg & ~byte_mask) | (dat_i & byte_mask)) & 32'h0000_0001;
        default: ;
      endcase
    end
    if (cyc_i && stb_i && !ack_reg && !we_i)
    begin
      case (adr_i)
        occ_pkg::ADDR_CTRL:   dat_next = compare_control_reg;
        occ_pkg::ADDR_PRI:    dat_next = primary_compare_value_reg;
        occ_pkg::ADDR_SEC:    dat_next = secondary_compare_value_reg;
        occ_pkg::ADDR_STATUS: dat_next = status_reg;
        occ_pkg::ADDR_MASK:   dat_next = mask_reg;
        default:              dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_control_reg         <= occ_pkg::CTRL_RESET;
      primary_compare_value_reg   <= occ_pkg::VALUE_RESET;
      secondary_compare_value_reg <= occ_pkg::VALUE_RESET;
      mask_reg                    <= 32'h0000_0000;
      ack_reg                     <= 1'b0;
      dat_reg                     <= 32'h0000_0000;
    end
    else
    begin
      compare_control_reg         <= compare_control_next;
      primary_compare_value_reg   <= primary_compare_value_next;
      secondary_compare_value_reg <= secondary_compare_value_next;
      mask_reg                    <= mask_next;
      ack_reg                     <= ack_next;
      dat_reg                     <= dat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequencer and pin
  logic set_flag;

  always_comb
  begin
    state_next = state_reg;
    pin_next   = pin_reg;
    set_flag   = 1'b0;
    if (ctrl_wr)
    begin
      // Re-arm on every active mode write, off and unused codes go idle; timer is left running
      state_next = occ_pkg::ST_LEAD;
      case (wr_ctrl[occ_pkg::CTRL_MODE_LSB +: 3])
        occ_pkg::MODE_HIGH:   pin_next = 1'b0;
        occ_pkg::MODE_LOW:    pin_next = 1'b1;
        occ_pkg::MODE_TOGGLE: pin_next = pin_reg;
        occ_pkg::MODE_PULSE:  pin_next = 1'b0;
        default:              state_next = occ_pkg::ST_IDLE;
      endcase
    end
    else if (run)
    begin
      case (state_reg)
        occ_pkg::ST_LEAD:
        begin
          if (ev_pri)
          begin
            case (compare_mode_field)
              occ_pkg::MODE_HIGH:
              begin
                pin_next   = 1'b1;
                set_flag   = 1'b1;
                state_next = occ_pkg::ST_DONE;
              end
              occ_pkg::MODE_LOW:
              begin
                pin_next   = 1'b0;
                set_flag   = 1'b1;
                state_next = occ_pkg::ST_DONE;
              end
              occ_pkg::MODE_TOGGLE:
              begin
                pin_next = !pin_reg;
                set_flag = 1'b1;
              end
              occ_pkg::MODE_PULSE:
              begin
                pin_next   = 1'b1;
                state_next = occ_pkg::ST_TRAIL;
              end
              default: state_next = occ_pkg::ST_IDLE;
            endcase
          end
        end
        occ_pkg::ST_TRAIL:
        begin
          if (ev_sec)
          begin
            pin_next   = 1'b0;
            set_flag   = 1'b1;
            state_next = occ_pkg::ST_DONE;
          end
        end
        default: ;
      endcase
    end
  end

  // Set wins over a read-clear in the same cycle
  always_comb
  begin
    status_next = status_reg;
    if (status_rd)
    begin
      status_next = 32'h0000_0000;
    end
    if (set_flag)
    begin
      status_next[occ_pkg::IRQ_CMP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg  <= occ_pkg::ST_IDLE;
      pin_reg    <= 1'b0;
      status_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg  <= state_next;
      pin_reg    <= pin_next;
      status_reg <= status_next;
    end
  end

  assign dat_o                = dat_reg;
  assign ack_o                = ack_reg;
  assign compare_output_pin_o = pin_reg;
  assign irq_o                = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_high_mode;
    ctrl_wr && (wr_ctrl[2:0] == 3'h1) |=> !pin_reg ##0 (state_reg == occ_pkg::ST_LEAD);
  endproperty
  a_high_mode: assert property (p_high_mode) else $error("Drive high init wrong");

  property p_low_mode;
    ctrl_wr && (wr_ctrl[2:0] == 3'h2) |=> pin_reg;
  endproperty
  a_low_mode: assert property (p_low_mode) else $error("Drive low init wrong");

  property p_toggle;
    !ctrl_wr && run && (compare_mode_field == 3'h3) && (state_reg == occ_pkg::ST_LEAD) && ev_pri
      |=> pin_reg != $past(pin_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle missed");

  property p_pulse_init;
    ctrl_wr && (wr_ctrl[2:0] == 3'h4) |=> !pin_reg && (state_reg == occ_pkg::ST_LEAD);
  endproperty
  a_pulse_init: assert property (p_pulse_init) else $error("Pulse init wrong");

  property p_lead;
    !ctrl_wr && run && (compare_mode_field == 3'h4) && (state_reg == occ_pkg::ST_LEAD) && ev_pri
      |=> pin_reg && (state_reg == occ_pkg::ST_TRAIL);
  endproperty
  a_lead: assert property (p_lead) else $error("Leading edge missed");

  property p_trail;
    !ctrl_wr && run && (state_reg == occ_pkg::ST_TRAIL) && ev_sec
      |=> !pin_reg && status_reg[0] && (state_reg == occ_pkg::ST_DONE);
  endproperty
  a_trail: assert property (p_trail) else $error("Trailing edge wrong");

  // A finished pulse must not restart until software writes the control word
  property p_done;
    (state_reg == occ_pkg::ST_DONE) && !ctrl_wr |=> $stable(pin_reg) && (state_reg == occ_pkg::ST_DONE);
  endproperty
  a_done: assert property (p_done) else $error("Pin moved after done");

  property p_irq_gate;
    irq_o == (status_reg[0] && mask_reg[0]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("Masked interrupt seen");

  property p_off;
    !ctrl_wr && !run |=> $stable(pin_reg) && $stable(state_reg) && !$rose(status_reg[0]);
  endproperty
  a_off: assert property (p_off) else $error("Pin moved while off");

  property p_clear;
    status_rd && !set_flag |=> !status_reg[0];
  endproperty
  a_clear: assert property (p_clear) else $error("Flag clear late");

  c_pulse:  cover property (state_reg == occ_pkg::ST_TRAIL ##[1:1000] state_reg == occ_pkg::ST_DONE);
  c_toggle: cover property (compare_mode_field == 3'h3 && ev_pri && run);
  c_irq:    cover property (irq_o ##[1:20] !irq_o);

endmodule // occ_top

// [verification/occ_timer_model.sv]
`timescale 1ns/10ps
// Time base model: tick_o marks a fresh count, div_i sets the pace at one count per div_i+1 enabled clocks
module occ_timer_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        en_i,
  input  wire logic [3:0]  div_i,
  input  wire logic [31:0] period_i,
  output logic      [31:0] count_o,
  output logic             tick_o
);
  logic [3:0] pre_reg;
  always_ff @(posedge clk_i)
  begin
    tick_o <= 1'b0;
    if (rst_i)
    begin
      pre_reg <= 4'h0;
      count_o <= 32'h0000_0000;
    end
    else if (en_i && pre_reg == div_i)  // Count advances only while enabled
    begin
      pre_reg <= 4'h0;
      tick_o  <= 1'b1;
      count_o <= (count_o >= period_i) ? 32'h0000_0000 : count_o + 32'h0000_0001;  // Wrap at period
    end
    else if (en_i)
    begin
      pre_reg <= pre_reg + 4'h1;
    end
  end
endmodule // occ_timer_model

// [verification/occ_top_tb.sv]
`timescale 1ns/10ps
module occ_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic        en_a  = 1'b0;
  logic        en_b  = 1'b0;
  logic [3:0]  div_b = 4'h0;
  logic [31:0] dat_o, cnt_a, cnt_b, q;
  logic        ack_o, tick_a, tick_b, pin, irq_o, b;
  int          fails = 0;
  int          tests_run = 0;

  // Both periods sit above the secondary value so the trailing match can occur
  occ_timer_model u_tmr_a (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_a), .div_i(4'h0),
    .period_i(32'h0000_0020), .count_o(cnt_a), .tick_o(tick_a));
  occ_timer_model u_tmr_b (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_b), .div_i(div_b),
    .period_i(32'h0000_0020), .count_o(cnt_b), .tick_o(tick_b));
  occ_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .timer_a_count_i(cnt_a),
    .timer_a_tick_i(tick_a), .timer_b_count_i(cnt_b), .timer_b_tick_i(tick_b),
    .compare_output_pin_o(pin), .irq_o(irq_o));

  always #20 clk_i = ~clk_i;

  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout();
    fails++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask

  // Entered just after an edge; holds the request until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    for (n = 0; ack_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      if (n > 20)
        timeout();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_pin(input logic e);
    int n;
    @(posedge clk_i);
    for (n = 0; pin !== e; n++)
    begin
      @(posedge clk_i);
      if (n > 100)
        timeout();
    end
  endtask

  // Long enough to pass every count of a full wrap
  task automatic hold_pin(input logic e);
    repeat (80)
    begin
      @(posedge clk_i);
      chk(pin, e, "pin held");
    end
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, occ_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(q, occ_pkg::CTRL_RESET, "ctrl reset");
    wb(1'b0, 5'h14, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped");
    chk({pin, irq_o}, 2'b00, "outs reset");
    $display("test reset done");
    en_a <= 1'b1;
    wb(1'b1, occ_pkg::ADDR_PRI, 32'h0000_0005);
    wb(1'b1, occ_pkg::ADDR_SEC, 32'h0000_0008);
    for (int k = 0; k <= 1; k++)
    begin
      wb(1'b1, occ_pkg::ADDR_MASK, 32'(k));
      wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_0002);
      chk(pin, 1'b1, "preset high");
      wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8004);
      chk(pin, 1'b0, "pulse init");
      wait_pin(1'b1);
      chk(cnt_a, 32'h0000_0006, "lead");
      wait_pin(1'b0);
      chk(cnt_a, 32'h0000_0009, "trail");
      chk(irq_o, 32'(k), "irq");
      hold_pin(1'b0);
      wb(1'b1, occ_pkg::ADDR_MASK, 32'h0000_0001);
      chk(irq_o, 1'b1, "irq unmasked");
      wb(1'b0, occ_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0001, "status");
      chk(irq_o, 1'b0, "irq cleared");
    end
    $display("test pulse done");
    // Toggle keeps whatever level the drive-low run left behind
    for (int m = 1; m <= 3; m++)
    begin
      b = (m == 2) ? 1'b1 : 1'b0;
      wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8000 | 32'(m));
      chk(pin, b, "mode init");
      wait_pin(~b);
      if (m == 3)
        wait_pin(b);
    end
    $display("test modes done");
    en_a <= 1'b0;
    en_b <= 1'b1;
    div_b <= 4'h1;
    wb(1'b1, occ_pkg::ADDR_PRI, 32'h0001_0006);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8009);
    wait_pin(1'b1);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8029);
    hold_pin(1'b0);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8001);
    hold_pin(1'b0);
    $display("test select done");
    en_a <= 1'b1;
    wb(1'b1, occ_pkg::ADDR_PRI, 32'h0000_0005);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_0003);
    hold_pin(1'b0);
    wb(1'b0, occ_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0003, "ctrl kept");
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8000);
    hold_pin(1'b0);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8003);
    wait_pin(1'b1);
    wb(1'b1, occ_pkg::ADDR_CTRL, 32'h0000_8005);
    hold_pin(1'b1);
    $display("test enable done");
    complete_run();
  end
endmodule // occ_top_tb
